// file: include/arb_pkg.sv
// How it works
// - write and read channels run independently.
// - latched write address/data reach register side.
// - register read word registered back to bus.
// - one shared register address, loaded per access.
// - never write and read registers together.
// - write strobe with address, data, lanes valid.
// - register address counts 32-bit words.
// - four byte lanes, bit 0 is bits 7:0.
// - read request raised with valid address.
// - address held from request until read valid.
// - read word with valid forwarded to bus.
// - four 0x200-byte areas: engine, mac, gen, check.
// - upper address bits select the submodule.
// - lower bits pick word, upper bits pick submodule.
// - byte lanes ignored; full words always written.
// - read valid is request delayed two flops.
// - engine area start holds write-only controls.
// - offset 0 bit 0 drives engine reset_n.
// - offset 4: mode bits 1:0, reply enable 16.
// - offset 8 supplies source MAC low word.
`default_nettype none
package arb_pkg;
  localparam int ADDR_W  = 11;           // byte address span 0x000-0x7FF
  localparam int WORD_AW = 9;            // word address width
  localparam int DATA_W  = 32;
  localparam int LANE_W  = 4;
  localparam int IDX_W   = 7;            // word index inside one area
  localparam int AREAS   = 4;
  // area codes from upper word-address bits
  localparam logic [1:0] AREA_ENGINE = 2'h0;
  localparam logic [1:0] AREA_MAC    = 2'h1;
  localparam logic [1:0] AREA_GEN    = 2'h2;
  localparam logic [1:0] AREA_CHK    = 2'h3;
  // byte offsets of the engine control registers
  localparam logic [ADDR_W-1:0] OFS_ENGINE_RESET = 11'h000;
  localparam logic [ADDR_W-1:0] OFS_NET_OPTION   = 11'h004;
  localparam logic [ADDR_W-1:0] OFS_SRC_MAC_LOW  = 11'h008;
  // field positions
  localparam int BIT_ENGINE_RESET = 0;
  localparam int BIT_MODE_LO      = 0;
  localparam int BIT_MODE_HI      = 1;
  localparam int BIT_ARP_REPLY    = 16;
  // values after reset
  localparam logic        RST_ENGINE_RESET_N = 1'h0;
  localparam logic [1:0]  RST_DEST_MODE      = 2'h0;
  localparam logic        RST_ARP_REPLY      = 1'h0;
  localparam logic [31:0] RST_SRC_MAC_LOW    = 32'h0;
  localparam logic [1:0]  RESP_OKAY          = 2'h0;
  localparam int          RD_LATENCY         = 2;
  // one register write as presented on the register side
  typedef struct packed {
    logic [DATA_W-1:0] word;
    logic [LANE_W-1:0] lanes;
  } arb_reg_wr_t;
  // engine input controls held by the register file
  typedef struct packed {
    logic        reset_n;
    logic [1:0]  dest_mode;
    logic        arp_reply;
    logic [31:0] src_mac_low;
  } arb_engine_ctrl_t;
endpackage
`default_nettype wire

// file: src/arb_bridge.sv
`default_nettype none
module arb_bridge (
  input  wire logic                             clk,
  input  wire logic                             sys_rst,
  input  wire logic [arb_pkg::ADDR_W-1:0]       s_axi_awaddr,
  input  wire logic                             s_axi_awvalid,
  output logic                                  s_axi_awready,
  input  wire logic [arb_pkg::DATA_W-1:0]       s_axi_wdata,
  input  wire logic [arb_pkg::LANE_W-1:0]       s_axi_wstrb,
  input  wire logic                             s_axi_wvalid,
  output logic                                  s_axi_wready,
  output logic [1:0]                            s_axi_bresp,
  output logic                                  s_axi_bvalid,
  input  wire logic                             s_axi_bready,
  input  wire logic [arb_pkg::ADDR_W-1:0]       s_axi_araddr,
  input  wire logic                             s_axi_arvalid,
  output logic                                  s_axi_arready,
  output logic [arb_pkg::DATA_W-1:0]            s_axi_rdata,
  output logic [1:0]                            s_axi_rresp,
  output logic                                  s_axi_rvalid,
  input  wire logic                             s_axi_rready,
  output logic                                  engine_reset_n,
  output logic [1:0]                            dest_mac_mode_sel,
  output logic                                  arp_icmp_reply_en,
  output logic [31:0]                           source_mac_value
);
  // area code of a word address
  function automatic logic [1:0] area_of(
    input logic [arb_pkg::WORD_AW-1:0] a);
    area_of = a[arb_pkg::WORD_AW-1 -: 2];
  endfunction
  // word address of a byte address
  function automatic logic [arb_pkg::WORD_AW-1:0] word_of(
    input logic [arb_pkg::ADDR_W-1:0] a);
    word_of = a[arb_pkg::ADDR_W-1:2];
  endfunction

  // ---------------- write channel state ----------------
  logic                         aw_full_q, aw_full_d;     // address latched
  logic [arb_pkg::ADDR_W-1:0]   aw_addr_q, aw_addr_d;
  logic                         w_full_q, w_full_d;       // data latched
  arb_pkg::arb_reg_wr_t         w_hold_q, w_hold_d;
  logic                         wr_busy_q, wr_busy_d;     // issued, no resp yet
  logic                         bvalid_q, bvalid_d;
  logic                         awready_q, awready_d;
  logic                         wready_q, wready_d;
  logic                         wr_issue;                 // register write now
  // ---------------- read channel state ----------------
  logic                         ar_full_q, ar_full_d;
  logic [arb_pkg::ADDR_W-1:0]   ar_addr_q, ar_addr_d;
  logic                         rd_open_q, rd_open_d;     // ar taken, r not done
  logic                         rd_busy_q, rd_busy_d;     // register read running
  logic                         rvalid_q, rvalid_d;
  logic [arb_pkg::DATA_W-1:0]   rdata_q, rdata_d;
  logic                         arready_q, arready_d;
  logic                         rd_issue;                 // register read now
  // ---------------- register side ----------------
  logic [arb_pkg::WORD_AW-1:0]  reg_word_addr_q, reg_word_addr_d;
  logic                         reg_write_strobe_q, reg_write_strobe_d;
  arb_pkg::arb_reg_wr_t         reg_wr_q, reg_wr_d;       // word and lanes
  logic                         reg_read_request_q, reg_read_request_d;
  logic                         rreq_stage_q, rreq_stage_d;
  logic                         reg_read_valid_q, reg_read_valid_d;
  logic [arb_pkg::DATA_W-1:0]   sub_word_q [arb_pkg::AREAS];
  logic [arb_pkg::DATA_W-1:0]   sub_word_d [arb_pkg::AREAS];
  logic [1:0]                   sel_area_q, sel_area_d;   // second mux level
  logic [arb_pkg::DATA_W-1:0]   reg_read_word_q, reg_read_word_d;
  arb_pkg::arb_engine_ctrl_t    ctrl_q, ctrl_d;

  // issue arbitration: a running read owns the shared address, and a
  // pending write beats a pending read in the same cycle
  assign wr_issue = aw_full_q & w_full_q & ~wr_busy_q & ~rd_busy_q;
  assign rd_issue = ar_full_q & ~rd_busy_q & ~wr_issue;

  // write address and data captured independently
  always_comb begin
    aw_full_d = aw_full_q;
    aw_addr_d = aw_addr_q;
    w_full_d  = w_full_q;
    w_hold_d  = w_hold_q;
    wr_busy_d = wr_busy_q;
    bvalid_d  = bvalid_q;
    if (s_axi_awvalid && awready_q) begin
      aw_full_d = 1'b1;
      aw_addr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_q) begin
      w_full_d = 1'b1;
      w_hold_d = '{word: s_axi_wdata, lanes: s_axi_wstrb};
    end
    if (wr_issue) begin                           // handed to register side
      aw_full_d = 1'b0;
      w_full_d  = 1'b0;
      wr_busy_d = 1'b1;
    end
    // response only once the strobe has been on the register side
    if (reg_write_strobe_q) begin
      bvalid_d = 1'b1;
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_d  = 1'b0;
      wr_busy_d = 1'b0;
    end
    // one write outstanding: no new beat until the response is taken
    awready_d = ~aw_full_d & ~wr_busy_d;
    wready_d  = ~w_full_d & ~wr_busy_d;
  end

  // write channel registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      aw_full_q <= 1'b0;
      aw_addr_q <= '0;
      w_full_q  <= 1'b0;
      w_hold_q  <= '0;
      wr_busy_q <= 1'b0;
      bvalid_q  <= 1'b0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
    end else begin
      aw_full_q <= aw_full_d;
      aw_addr_q <= aw_addr_d;
      w_full_q  <= w_full_d;
      w_hold_q  <= w_hold_d;
      wr_busy_q <= wr_busy_d;
      bvalid_q  <= bvalid_d;
      awready_q <= awready_d;
      wready_q  <= wready_d;
    end
  end

  // read address capture and read data return
  always_comb begin
    ar_full_d = ar_full_q;
    ar_addr_d = ar_addr_q;
    rd_open_d = rd_open_q;
    rd_busy_d = rd_busy_q;
    rvalid_d  = rvalid_q;
    rdata_d   = rdata_q;
    if (s_axi_arvalid && arready_q) begin
      ar_full_d = 1'b1;
      ar_addr_d = s_axi_araddr;
      rd_open_d = 1'b1;
    end
    if (rd_issue) begin
      ar_full_d = 1'b0;
      rd_busy_d = 1'b1;
    end
    if (reg_read_valid_q) begin
      rd_busy_d = 1'b0;
      rvalid_d  = 1'b1;
      rdata_d   = reg_read_word_q;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d  = 1'b0;
      rd_open_d = 1'b0;
    end
    arready_d = ~rd_open_d;
  end

  // read channel registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ar_full_q <= 1'b0;
      ar_addr_q <= '0;
      rd_open_q <= 1'b0;
      rd_busy_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= '0;
      arready_q <= 1'b0;
    end else begin
      ar_full_q <= ar_full_d;
      ar_addr_q <= ar_addr_d;
      rd_open_q <= rd_open_d;
      rd_busy_q <= rd_busy_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      arready_q <= arready_d;
    end
  end

  // first mux level: each area loads zero on a read request, low bits unused; the
  // engine controls are write-only and the other areas live elsewhere,
  // so every area answers zero here
  genvar g;
  generate
    for (g = 0; g < arb_pkg::AREAS; g++) begin : g_sub
      always_comb begin
        sub_word_d[g] = sub_word_q[g];
        if (reg_read_request_q) begin
          sub_word_d[g] = '0;
        end
      end
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          sub_word_q[g] <= '0;
        end else begin
          sub_word_q[g] <= sub_word_d[g];
        end
      end
    end
  endgenerate

  // register side: shared address, strobes, two-stage read timing
  always_comb begin
    reg_word_addr_d    = reg_word_addr_q;         // held while reading
    reg_wr_d           = reg_wr_q;
    reg_write_strobe_d = wr_issue;
    reg_read_request_d = rd_issue;
    if (wr_issue) begin
      reg_word_addr_d = word_of(aw_addr_q);
      reg_wr_d        = w_hold_q;
    end else if (rd_issue) begin
      reg_word_addr_d = word_of(ar_addr_q);
    end
    rreq_stage_d     = reg_read_request_q;
    reg_read_valid_d = rreq_stage_q;
    sel_area_d       = area_of(reg_word_addr_q);
    reg_read_word_d  = reg_read_word_q;
    if (rreq_stage_q) begin
      reg_read_word_d = sub_word_q[sel_area_q];
    end
    // byte lanes are carried but the file writes whole words
    ctrl_d = ctrl_q;
    if (reg_write_strobe_q &&
        area_of(reg_word_addr_q) == arb_pkg::AREA_ENGINE) begin
      case (reg_word_addr_q)
        word_of(arb_pkg::OFS_ENGINE_RESET): begin
          ctrl_d.reset_n =
            reg_wr_q.word[arb_pkg::BIT_ENGINE_RESET];
        end
        word_of(arb_pkg::OFS_NET_OPTION): begin
          ctrl_d.dest_mode = reg_wr_q.word[arb_pkg::BIT_MODE_HI:
                                           arb_pkg::BIT_MODE_LO];
          ctrl_d.arp_reply =
            reg_wr_q.word[arb_pkg::BIT_ARP_REPLY];
        end
        word_of(arb_pkg::OFS_SRC_MAC_LOW): begin
          ctrl_d.src_mac_low = reg_wr_q.word;
        end
        default: begin
          ctrl_d = ctrl_q;                            // unmapped: no effect
        end
      endcase
    end
  end

  // register side registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_word_addr_q    <= '0;
      reg_wr_q           <= '0;
      reg_write_strobe_q <= 1'b0;
      reg_read_request_q <= 1'b0;
      rreq_stage_q       <= 1'b0;
      reg_read_valid_q   <= 1'b0;
      sel_area_q         <= arb_pkg::AREA_ENGINE;
      reg_read_word_q    <= '0;
      ctrl_q             <= '{reset_n:     arb_pkg::RST_ENGINE_RESET_N,
                              dest_mode:   arb_pkg::RST_DEST_MODE,
                              arp_reply:   arb_pkg::RST_ARP_REPLY,
                              src_mac_low: arb_pkg::RST_SRC_MAC_LOW};
    end else begin
      reg_word_addr_q    <= reg_word_addr_d;
      reg_wr_q           <= reg_wr_d;
      reg_write_strobe_q <= reg_write_strobe_d;
      reg_read_request_q <= reg_read_request_d;
      rreq_stage_q       <= rreq_stage_d;
      reg_read_valid_q   <= reg_read_valid_d;
      sel_area_q         <= sel_area_d;
      reg_read_word_q    <= reg_read_word_d;
      ctrl_q             <= ctrl_d;
    end
  end

  // outputs straight from flops; bresp and rresp tied to RESP_OKAY
  assign s_axi_awready     = awready_q;
  assign s_axi_wready      = wready_q;
  assign s_axi_bvalid      = bvalid_q;
  assign s_axi_bresp       = arb_pkg::RESP_OKAY;
  assign s_axi_arready     = arready_q;
  assign s_axi_rvalid      = rvalid_q;
  assign s_axi_rdata       = rdata_q;
  assign s_axi_rresp       = arb_pkg::RESP_OKAY;
  assign engine_reset_n    = ctrl_q.reset_n;
  assign dest_mac_mode_sel = ctrl_q.dest_mode;
  assign arp_icmp_reply_en = ctrl_q.arp_reply;
  assign source_mac_value  = ctrl_q.src_mac_low;

  // checks on the block's own behaviour
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_rd_start;
    reg_read_request_q;
  endsequence
  sequence s_rd_done;
    ##2 reg_read_valid_q;
  endsequence
  a_no_rw_overlap: assert property (
    !(reg_write_strobe_q && reg_read_request_q))
    else $error("register write and read in same cycle");
  a_rd_valid_two: assert property (s_rd_start |-> s_rd_done)
    else $error("read valid not two cycles after request");
  a_rd_addr_hold: assert property (
    reg_read_request_q |=> $stable(reg_word_addr_q) [*2])
    else $error("register address moved during read");
  a_bresp_after_wr: assert property (
    $rose(s_axi_bvalid) |-> $past(reg_write_strobe_q))
    else $error("write response before register write");
  a_rvalid_from_reg: assert property (
    reg_read_valid_q |=> s_axi_rvalid && s_axi_rdata == $past(reg_read_word_q))
    else $error("read word not forwarded");
  a_wr_addr_word: assert property (
    wr_issue |=> reg_write_strobe_q
                 && reg_word_addr_q == $past(aw_addr_q[10:2]))
    else $error("write word address wrong");
  a_wr_lanes_kept: assert property (
    wr_issue |=> reg_wr_q == $past(w_hold_q))
    else $error("write word or lanes not presented");
  a_reset_bit_map: assert property (
    reg_write_strobe_q && reg_word_addr_q == 9'h000
    |=> engine_reset_n == $past(reg_wr_q.word[0]))
    else $error("engine reset bit not taken");
  a_option_map: assert property (
    reg_write_strobe_q && reg_word_addr_q == 9'h001
    |=> dest_mac_mode_sel == $past(reg_wr_q.word[1:0])
        && arp_icmp_reply_en == $past(reg_wr_q.word[16]))
    else $error("option register fields wrong");
  a_src_mac_map: assert property (
    reg_write_strobe_q && reg_word_addr_q == 9'h002
    |=> source_mac_value == $past(reg_wr_q.word))
    else $error("source mac word not taken");
  a_one_read_open: assert property (
    s_axi_rvalid |-> !s_axi_arready)
    else $error("second read accepted while one open");
endmodule
`default_nettype wire

// file: verification/arb_cpu_model.sv
`default_nettype none
// bus master on the cpu side: drives on falling edges, samples readies and data on rising, polls bvalid/rvalid on falling
module arb_cpu_model (
  input  wire logic                         clk,
  output logic [arb_pkg::ADDR_W-1:0]        s_axi_awaddr,
  output logic                              s_axi_awvalid,
  input  wire logic                         s_axi_awready,
  output logic [arb_pkg::DATA_W-1:0]        s_axi_wdata,
  output logic [arb_pkg::LANE_W-1:0]        s_axi_wstrb,
  output logic                              s_axi_wvalid,
  input  wire logic                         s_axi_wready,
  input  wire logic [1:0]                   s_axi_bresp,
  input  wire logic                         s_axi_bvalid,
  output logic                              s_axi_bready,
  output logic [arb_pkg::ADDR_W-1:0]        s_axi_araddr,
  output logic                              s_axi_arvalid,
  input  wire logic                         s_axi_arready,
  input  wire logic [arb_pkg::DATA_W-1:0]   s_axi_rdata,
  input  wire logic [1:0]                   s_axi_rresp,
  input  wire logic                         s_axi_rvalid,
  output logic                              s_axi_rready
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle bus at time zero
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_wvalid, s_axi_bready, s_axi_araddr, s_axi_arvalid} = '0;
    s_axi_rready = 1'b0;
  end
  // one write; stall delays bready to prove bvalid stands
  task automatic write(input logic [10:0] a, input logic [31:0] d,
      input logic [3:0] s, input int stall, output logic [1:0] resp,
      output int lat, output logic held);
    logic aw_done;
    logic w_done;
    int   n;
    @(negedge clk);
    s_axi_awaddr  = a;
    s_axi_awvalid = 1'b1;
    s_axi_wdata   = d;
    s_axi_wstrb   = s;
    s_axi_wvalid  = 1'b1;
    s_axi_bready  = (stall == 0);
    aw_done = 1'b0;
    w_done  = 1'b0;
    n = 0;
    while (!(aw_done && w_done) && n < 50) begin
      @(posedge clk);
      n++;
      if (s_axi_awready) aw_done = 1'b1;
      if (s_axi_wready) w_done = 1'b1;
      @(negedge clk);
      // released address and data lines show the inverse, never a stale copy
      if (aw_done) begin
        s_axi_awvalid = 1'b0;
        s_axi_awaddr  = ~a;
      end
      if (w_done) begin
        s_axi_wvalid = 1'b0;
        s_axi_wdata  = ~d;
      end
    end
    lat = 0;
    while (lat < 60) begin
      lat++;
      if (s_axi_bvalid) break;
      @(negedge clk);
    end
    repeat (stall) @(negedge clk);
    s_axi_bready = 1'b1;
    @(posedge clk);
    held = s_axi_bvalid;
    resp = s_axi_bresp;
    @(negedge clk);
    s_axi_bready = 1'b0;
  endtask
  // one read; latency counted in falling edges after the take
  task automatic read(input logic [10:0] a, input int stall,
      output logic [31:0] d, output logic [1:0] resp, output int lat,
      output logic held);
    int n;
    @(negedge clk);
    s_axi_araddr  = a;
    s_axi_arvalid = 1'b1;
    s_axi_rready  = (stall == 0);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (!s_axi_arready && n < 50);
    @(negedge clk);
    s_axi_arvalid = 1'b0;
    s_axi_araddr  = ~a;
    lat = 0;
    while (lat < 60) begin
      lat++;
      if (s_axi_rvalid) break;
      @(negedge clk);
    end
    repeat (stall) @(negedge clk);
    s_axi_rready = 1'b1;
    @(posedge clk);
    held = s_axi_rvalid;
    d    = s_axi_rdata;
    resp = s_axi_rresp;
    @(negedge clk);
    s_axi_rready = 1'b0;
  endtask
endmodule
`default_nettype wire

// file: verification/arb_bridge_tb_top.sv
`default_nettype none
module arb_bridge_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                         clk = 1'b0;
  logic                         sys_rst = 1'b1;
  logic [arb_pkg::ADDR_W-1:0]   s_axi_awaddr, s_axi_araddr;
  logic [arb_pkg::DATA_W-1:0]   s_axi_wdata, s_axi_rdata;
  logic [arb_pkg::LANE_W-1:0]   s_axi_wstrb;
  logic [1:0]                   s_axi_bresp, s_axi_rresp, dest_mac_mode_sel;
  logic                         s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic                         s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic                         s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic                         s_axi_rready, engine_reset_n;
  logic                         arp_icmp_reply_en;
  logic [31:0]                  source_mac_value;
  arb_pkg::arb_engine_ctrl_t    exp_c;      // expected control outputs
  int                           checks = 0;
  int                           fail_count = 0;
  logic [31:0]                  opt_w;      // option word under test
  // write targets that touch no control, and reads across all areas
  localparam logic [10:0] FAR_A [4] = '{11'h00C, 11'h208, 11'h404, 11'h7FC};
  localparam logic [10:0] RD_A [6] = '{11'h000, 11'h004, 11'h008, 11'h200,
                                       11'h400, 11'h7FC};
  // 250 MHz clock
  always #2 clk = ~clk;
  arb_bridge DUT (.clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .engine_reset_n, .dest_mac_mode_sel,
    .arp_icmp_reply_en, .source_mac_value);
  arb_cpu_model cpu (.clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);
  // verdict in one place
  task automatic summarize();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  // control outputs against the expected struct
  task automatic ctl();
    chk(64'({engine_reset_n, dest_mac_mode_sel, arp_icmp_reply_en,
             source_mac_value}), 64'(exp_c));
  endtask
  // write with response code, latency window and standing bvalid
  task automatic wr(input logic [10:0] a, input logic [31:0] d,
      input logic [3:0] s, input int stall, input int lo, input int hi);
    logic [1:0] resp;
    int         lat;
    logic       held;
    cpu.write(a, d, s, stall, resp, lat, held);
    chk(64'(resp), 64'(arb_pkg::RESP_OKAY));
    chk(64'(lat >= lo && lat <= hi), 64'h1);
    chk(64'(held), 64'h1);
  endtask
  // read: engine area is write-only, other areas absent, so zero back
  task automatic rd(input logic [10:0] a, input int stall, input int lo,
      input int hi);
    logic [31:0] d;
    logic [1:0]  resp;
    int          lat;
    logic        held;
    cpu.read(a, stall, d, resp, lat, held);
    chk(64'(d), 64'h0);
    chk(64'(resp), 64'(arb_pkg::RESP_OKAY));
    chk(64'(lat >= lo && lat <= hi), 64'h1);
    chk(64'(held), 64'h1);
  endtask
  task automatic do_reset();
    sys_rst = 1'b1;
    repeat (6) @(negedge clk);
    sys_rst = 1'b0;
  endtask
  // hang guard, far above the roughly 145 cycles the tests take
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    $display("watchdog expired at %0t ns", $time);
    summarize();
  end
  // main sequence
  initial begin
    exp_c = '0;
    do_reset();
    ctl();
    chk(64'({s_axi_bvalid, s_axi_rvalid}), 64'h0);
    // readies come up at the first edge after release
    @(negedge clk);
    chk(64'({s_axi_awready, s_axi_wready, s_axi_arready}), 64'h7);
    wr(11'h000, 32'h0000_0001, 4'hF, 0, 3, 3);
    exp_c.reset_n = 1'b1;
    ctl();
    // every mode value, reply enable toggled, noise in unused bits
    for (int m = 0; m < 4; m++) begin
      opt_w = 32'(m) | 32'h0000_FFFC | (32'(m & 1) << 16);
      wr(11'h004, opt_w, 4'hF, m, 3, 3);
      exp_c.dest_mode = 2'(m);
      exp_c.arp_reply = 1'(m);
      ctl();
    end
    // one lane enabled still writes the full word
    wr(11'h008, 32'hA5C3_1E7F, 4'h1, 2, 3, 3);
    exp_c.src_mac_low = 32'hA5C3_1E7F;
    ctl();
    wr(11'h008, 32'h5A3C_E180, 4'h0, 0, 3, 3);
    exp_c.src_mac_low = 32'h5A3C_E180;
    ctl();
    // neighbouring word and other areas leave controls alone
    foreach (FAR_A[i])
      wr(FAR_A[i], 32'hFFFF_FFFF, 4'hF, 0, 3, 3);
    ctl();
    chk(64'(source_mac_value), 64'h5A3C_E180);
    // reads across all four areas, some with rready stalled
    foreach (RD_A[i])
      rd(RD_A[i], i % 3, 5, 5);
    // write and read launched together must be serialised
    fork
      wr(11'h000, 32'h0000_0000, 4'hF, 0, 3, 6);
      rd(11'h004, 0, 5, 6);
    join
    exp_c.reset_n = 1'b0;
    ctl();
    wr(11'h000, 32'h0000_0001, 4'hF, 0, 3, 3);
    exp_c.reset_n = 1'b1;
    ctl();
    // reset in mid-run returns controls to their reset values
    do_reset();
    exp_c = '0;
    ctl();
    rd(11'h008, 1, 5, 5);
    summarize();
  end
endmodule
`default_nettype wire
